// ### hw/sfcr_pkg.sv
// Constants for the supply status and recovery limit register bank.
package sfcr_pkg;
	localparam logic [6:0] ADDR_UPPER  = 7'h3e;
	localparam logic [6:0] ADDR_LOWER  = 7'h3f;
	localparam logic [6:0] ADDR_STAT_B = 7'h40;
	localparam logic [6:0] ADDR_STAT_A = 7'h41;
	localparam logic [7:0] UPPER_RST   = 8'ha8;
	localparam logic [7:0] LOWER_RST   = 8'h98;
	localparam logic [7:0] STAT_B_RST  = 8'h00;
	localparam logic [7:0] STAT_A_POR  = 8'h80;
	localparam logic [7:0] STAT_A_SOFT = 8'h00;
	localparam logic [7:0] RC_MASK_B   = 8'h5f;
	localparam logic [7:0] RC_MASK_A   = 8'hff;
	localparam logic [7:0] ZERO_BYTE   = 8'h00;
	localparam int SB_BAT_UV  = 6;
	localparam int SB_R3_OC   = 4;
	localparam int SB_R3_UV   = 3;
	localparam int SB_R3_OT   = 2;
	localparam int SB_MAIN_OV = 1;
	localparam int SB_MAIN_PW = 0;
	localparam int SA_POR     = 7;
	localparam logic [4:0] HDR_LAST   = 5'h07;
	localparam logic [4:0] HDR_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CNT_OVER   = 5'h11;
	localparam logic [1:0] CLK_SEL_80 = 2'h0;
	localparam logic [1:0] CLK_SEL_40 = 2'h1;
	localparam logic [1:0] CLK_SEL_20 = 2'h2;
	localparam logic [6:0] MHZ_80 = 7'h50;
	localparam logic [6:0] MHZ_40 = 7'h28;
	localparam logic [6:0] MHZ_20 = 7'h14;
	localparam logic [6:0] MHZ_10 = 7'h0a;
	typedef enum logic {ST_IDLE, ST_SHIFT} sfcr_state_t;
endpackage

// ### hw/sfcr_regs.sv
// Serial register bank: recovery limits and supply fail status.
//
// Operation
// R1: 8-bit upper limit, resets 0xa8, clamps high bit times, kept on restart.
// R2: Lower limit, 8 bits, resets 0x98, clamps low bit times, kept on restart.
// R3: Upper limit at 0x3e, lower at 0x3f, both fully read-write.
// R4: Host programs bit time and limits in the recommended pairings.
// R5: Host avoids clock selections that overflow the time quanta counter.
// R6: Host avoids clock selections too coarse for the chosen baud rate.
// R7: A command is sixteen bits: address with mode bit, then data byte.
// R8: Data D0..D7 is frame bits 8..15; address and mode bits 0..7.
// R9: Mode bit 0 on a status register reads without changing it.
// R10: Mode bit 1 clears the clearable bits of the addressed status byte.
// R11: Status flags stay set until cleared by command.
// R12: Reserved bits read zero and ignore writes and clears.
// R13: Status B at 0x40 resets to zero; bits 7 and 5 always zero.
// R14: Status B bit 6 latches battery undervoltage.
// R15: B bits 4,3,2 latch third regulator overcurrent, undervoltage, heat.
// R16: Status B bit 1 latches main regulator overvoltage.
// R17: Status B bit 0 latches main regulator undervoltage prewarning.
// R18: Status A at 0x41; top bit depends on reset kind, rest reset zero.
// R19: Clock select 00/01/10/11 gives 80/40/20/10 MHz to recovery.
// R20: Power-on flag is set by power-on reset, cleared by soft reset.
// R21: Clears touch clearable bits only; a present condition keeps its flag.
// R22: Data returned in a clear frame is the content before the clear.
`timescale 1ns/1ps
`default_nettype none
module sfcr_regs
	import sfcr_pkg::*;
(
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       soft_reset,
	// Serial register port.
	input  wire logic       spi_cs_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_sdi,
	output var  logic       spi_sdo,
	output logic            spi_sdo_oe,
	// Supply monitor events.
	input  wire logic       battery_undervoltage_flag,
	input  wire logic       third_reg_overcurrent_flag,
	input  wire logic       third_reg_undervoltage_flag,
	input  wire logic       third_reg_overtemp_flag,
	input  wire logic       main_reg_overvoltage_flag,
	input  wire logic       main_reg_prewarning_flag,
	input  wire logic [6:0] supply_a_events,
	// Recovery engine side.
	input  wire logic [1:0] recovery_clock_select,
	input  wire logic [7:0] bit_time_setting,
	output var  logic [7:0] upper_bound_field,
	output var  logic [7:0] lower_bound_field,
	output var  logic [7:0] bit_time_clamped,
	output var  logic [6:0] recovery_clock_mhz
);

////////////////////////////////////////////////////////////////////////////
	sfcr_state_t state;
	logic        sclk_q;
	logic [4:0]  bit_cnt;
	logic [15:0] rx;
	logic [7:0]  tx;
	logic [6:0]  frm_addr;
	logic        frm_mode;
	logic [7:0]  stat_b;
	logic [7:0]  stat_a;
	logic [7:0]  ev_b;

	// Pins are synchronous to sys_clk, so edges are found by one delay.
	wire         in_frame   = (state == ST_SHIFT);
	wire         sclk_rise  = in_frame & spi_sclk & ~sclk_q;
	wire         sclk_fall  = in_frame & ~spi_sclk & sclk_q;
	wire         cs_start   = (state == ST_IDLE) & ~spi_cs_n;
	wire         cs_end     = in_frame & spi_cs_n;
	wire [15:0]  next_rx    = {spi_sdi, rx[15:1]};
	wire [6:0]   hdr_addr   = next_rx[14:8];
	wire         hdr_mode   = next_rx[15];
	wire         hdr_take   = sclk_rise & (bit_cnt == HDR_LAST);
	// Frames of any other length are dropped whole.
	wire         frame_ok   = cs_end & (bit_cnt == FRAME_BITS);
	wire         commit     = frame_ok & frm_mode;
	wire [7:0]   frm_data   = rx[15:8];
	wire         wr_upper   = commit & (frm_addr == ADDR_UPPER);
	wire         wr_lower   = commit & (frm_addr == ADDR_LOWER);
	wire         clr_b      = commit & (frm_addr == ADDR_STAT_B);
	wire         clr_a      = commit & (frm_addr == ADDR_STAT_A);
	wire [7:0]   clr_mask_b = clr_b ? RC_MASK_B : ZERO_BYTE;
	wire [7:0]   clr_mask_a = clr_a ? RC_MASK_A : ZERO_BYTE;
	wire [7:0]   ev_a       = {1'b0, supply_a_events};
	wire [7:0]   next_stat_b = ((stat_b & ~clr_mask_b) | ev_b) & RC_MASK_B;
	wire [7:0]   next_stat_a = (stat_a & ~clr_mask_a) | ev_a;
	wire [7:0]   rd_mux =
		(hdr_addr == ADDR_UPPER)  ? upper_bound_field :
		(hdr_addr == ADDR_LOWER)  ? lower_bound_field :
		(hdr_addr == ADDR_STAT_B) ? stat_b :
		(hdr_addr == ADDR_STAT_A) ? stat_a : ZERO_BYTE;
	wire [7:0]   next_clamp =
		(bit_time_setting > upper_bound_field) ? upper_bound_field :
		(bit_time_setting < lower_bound_field) ? lower_bound_field :
		bit_time_setting;
	wire [6:0]   next_mhz =
		(recovery_clock_select == CLK_SEL_80) ? MHZ_80 :
		(recovery_clock_select == CLK_SEL_40) ? MHZ_40 :
		(recovery_clock_select == CLK_SEL_20) ? MHZ_20 : MHZ_10;

	assign spi_sdo_oe = in_frame;

	always_comb begin
		ev_b = ZERO_BYTE;
		ev_b[SB_BAT_UV]  = battery_undervoltage_flag; // R14
		ev_b[SB_R3_OC]   = third_reg_overcurrent_flag; // R15
		ev_b[SB_R3_UV]   = third_reg_undervoltage_flag; // R15
		ev_b[SB_R3_OT]   = third_reg_overtemp_flag; // R15
		ev_b[SB_MAIN_OV] = main_reg_overvoltage_flag; // R16
		ev_b[SB_MAIN_PW] = main_reg_prewarning_flag; // R17
	end

////////////////////////////////////////////////////////////////////////////
	// Frame receiver and reply shifter, least significant bit first.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state   <= ST_IDLE;
			sclk_q  <= 1'b0;
			bit_cnt <= 5'h00;
			rx      <= 16'h0000;
		end else begin
			sclk_q <= spi_sclk;
			if (cs_start) begin
				state   <= ST_SHIFT;
				bit_cnt <= 5'h00;
			end else if (cs_end) begin
				state <= ST_IDLE;
			end else if (sclk_rise) begin
				rx <= next_rx; // R8
				if (bit_cnt != CNT_OVER)
					bit_cnt <= bit_cnt + 5'h01; // R7
			end
		end
	end

	// The reply is sampled at the header, so a clear reads old data.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx       <= ZERO_BYTE;
			spi_sdo  <= 1'b0;
			frm_addr <= 7'h00;
			frm_mode <= 1'b0;
		end else if (cs_start) begin
			spi_sdo <= 1'b0;
		end else if (hdr_take) begin
			tx       <= rd_mux; // R22
			frm_addr <= hdr_addr; // R7
			frm_mode <= hdr_mode; // R9
		end else if (sclk_fall) begin
			if (bit_cnt >= HDR_BITS) begin
				spi_sdo <= tx[0]; // R8
				tx      <= {1'b0, tx[7:1]};
			end else begin
				spi_sdo <= 1'b0;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Limits survive restart; only power-on and soft reset reload them.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			upper_bound_field <= UPPER_RST; // R1
			lower_bound_field <= LOWER_RST; // R2
		end else if (soft_reset) begin
			upper_bound_field <= UPPER_RST; // R1
			lower_bound_field <= LOWER_RST; // R2
		end else begin
			if (wr_upper)
				upper_bound_field <= frm_data; // R3
			if (wr_lower)
				lower_bound_field <= frm_data; // R3
		end
	end

	// Flags only fall on a clear or a reset; a live event wins over a clear.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stat_b <= STAT_B_RST; // R13
			stat_a <= STAT_A_POR; // R18
		end else if (soft_reset) begin
			stat_b <= STAT_B_RST; // R13
			stat_a <= STAT_A_SOFT; // R20
		end else begin
			stat_b <= next_stat_b; // R10 R11 R12 R21
			stat_a <= next_stat_a; // R10 R11 R21
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bit_time_clamped   <= LOWER_RST;
			recovery_clock_mhz <= MHZ_80;
		end else begin
			bit_time_clamped   <= next_clamp; // R1 R2
			recovery_clock_mhz <= next_mhz; // R19
		end
	end

////////////////////////////////////////////////////////////////////////////
	sequence s_hdr;
		sclk_rise && (bit_cnt == HDR_LAST);
	endsequence

	property p_upper_soft;
		@(posedge sys_clk) disable iff (!nrst)
		soft_reset |=> upper_bound_field == UPPER_RST;
	endproperty
	a_upper_soft: assert property (p_upper_soft) // R1
		else $error("upper limit not reloaded by soft reset");

	property p_lower_soft;
		@(posedge sys_clk) disable iff (!nrst)
		soft_reset |=> lower_bound_field == LOWER_RST;
	endproperty
	a_lower_soft: assert property (p_lower_soft) // R2
		else $error("lower limit not reloaded by soft reset");

	property p_write_upper;
		@(posedge sys_clk) disable iff (!nrst)
		(wr_upper && !soft_reset) |=> upper_bound_field == $past(rx[15:8]);
	endproperty
	a_write_upper: assert property (p_write_upper) // R3
		else $error("upper limit write lost");

	property p_sticky;
		@(posedge sys_clk) disable iff (!nrst)
		(!clr_b && !soft_reset) |=> (stat_b & $past(stat_b)) == $past(stat_b);
	endproperty
	a_sticky: assert property (p_sticky) // R11
		else $error("status flag fell without a clear");

	property p_clear;
		@(posedge sys_clk) disable iff (!nrst)
		(clr_b && ev_b == ZERO_BYTE && !soft_reset) |=> stat_b == ZERO_BYTE;
	endproperty
	a_clear: assert property (p_clear) // R10
		else $error("clear frame left flags set");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!nrst)
		(battery_undervoltage_flag && !soft_reset) |=> stat_b[SB_BAT_UV];
	endproperty
	a_set_wins: assert property (p_set_wins) // R21
		else $error("battery undervoltage event lost");

	property p_reserved;
		@(posedge sys_clk) disable iff (!nrst)
		(stat_b & ~RC_MASK_B) == ZERO_BYTE;
	endproperty
	a_reserved: assert property (p_reserved) // R12
		else $error("reserved status bit set");

	property p_reply;
		@(posedge sys_clk) disable iff (!nrst)
		s_hdr ##1 !cs_start |-> tx == $past(rd_mux);
	endproperty
	a_reply: assert property (p_reply) // R22
		else $error("reply byte not sampled at the header");

	property p_clamp;
		@(posedge sys_clk) disable iff (!nrst)
		(bit_time_setting > upper_bound_field) |=>
			bit_time_clamped == $past(upper_bound_field);
	endproperty
	a_clamp: assert property (p_clamp) // R1
		else $error("bit time not clamped to upper limit");

	property p_clk_sel;
		@(posedge sys_clk) disable iff (!nrst)
		(recovery_clock_select == CLK_SEL_40) |=> recovery_clock_mhz == MHZ_40;
	endproperty
	a_clk_sel: assert property (p_clk_sel) // R19
		else $error("clock selection decode wrong");

	property p_por_soft;
		@(posedge sys_clk) disable iff (!nrst)
		soft_reset |=> !stat_a[SA_POR];
	endproperty
	a_por_soft: assert property (p_por_soft) // R20
		else $error("power-on flag survived soft reset");

endmodule
`default_nettype wire

// ### tb/sfcr_host.sv
// Host model that drives 16-bit register frames and gathers replies.
`timescale 1ns/1ps
`default_nettype none
module sfcr_host (
	// Clock and reply line.
	input  wire logic sys_clk,
	input  wire logic spi_sdo,
	// Frame lines.
	output var  logic spi_cs_n,
	output var  logic spi_sclk,
	output var  logic spi_sdi
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi  = 1'b1;
	end
	// Sends n bits of f, bit 0 first; reply bits 8..15 are taken at rises.
	task automatic xfer(input logic [15:0] f, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		@(posedge sys_clk);
		#1 spi_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (2) @(posedge sys_clk);
			#1 spi_sdi = f[i];
			repeat (2) @(posedge sys_clk);
			#1 if (i > 7) rd[i-8] = spi_sdo;
			spi_sclk = 1'b1;
			repeat (2) @(posedge sys_clk);
			#1 spi_sclk = 1'b0;
		end
		repeat (2) @(posedge sys_clk);
		// A released line is not left at its last value.
		#1 spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the recovery limit and supply status registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sfcr_pkg::*;
	logic sys_clk, nrst, soft_reset, cs_n, sclk, sdi, sdo;
	logic bat, oc, uv, ot, ov, pw, oe;
	logic [6:0] ev_a, mhz, va;
	logic [1:0] sel;
	logic [7:0] bt, up, lo, cl, r, hi_v, lo_v;
	logic [5:0] v;
	int bad_count, checks, cycles;
	logic [7:0] t_hi [2] = '{8'ha8, 8'h54};
	logic [7:0] t_lo [2] = '{8'h98, 8'h4c};
	logic [7:0] t_bt [2] = '{8'ha0, 8'h50};
	sfcr_regs i_sfcr_regs (.sys_clk(sys_clk), .nrst(nrst),
		.soft_reset(soft_reset), .spi_cs_n(cs_n), .spi_sclk(sclk),
		.spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe),
		.battery_undervoltage_flag(bat), .third_reg_overcurrent_flag(oc),
		.third_reg_undervoltage_flag(uv), .third_reg_overtemp_flag(ot),
		.main_reg_overvoltage_flag(ov), .main_reg_prewarning_flag(pw),
		.supply_a_events(ev_a), .recovery_clock_select(sel),
		.bit_time_setting(bt), .upper_bound_field(up),
		.lower_bound_field(lo), .bit_time_clamped(cl),
		.recovery_clock_mhz(mhz));
	sfcr_host host (.sys_clk(sys_clk), .spi_sdo(sdo), .spi_cs_n(cs_n),
		.spi_sclk(sclk), .spi_sdi(sdi));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic frm(input logic [6:0] a, input logic m, input logic [7:0] d,
		output logic [7:0] q);
		host.xfer({d, m, a}, 16, q);
	endtask
	task automatic pulse(input logic [5:0] b, input logic [6:0] a);
		{bat, oc, uv, ot, ov, pw} = b;
		ev_a = a;
		tick(1);
		{bat, oc, uv, ot, ov, pw} = 6'h00;
		ev_a = 7'h00;
	endtask
	task summarize;
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic logic [7:0] clamp(input logic [7:0] b, l, h);
		return (b > h) ? h : ((b < l) ? l : b);
	endfunction
	function automatic logic [7:0] bexp(input logic [5:0] b);
		return {1'b0, b[5], 1'b0, b[4:0]};
	endfunction
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(90));
		{nrst, soft_reset, sel, bt, ev_a} = '0;
		{bat, oc, uv, ot, ov, pw} = 6'h00;
		tick(5);
		nrst = 1'b1;
		chk(up, 8'ha8);
		chk(lo, 8'h98);
		chk({7'h00, oe}, 8'h00);
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, 8'h80);
		frm(ADDR_STAT_B, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		for (int s = 0; s < 4; s++) begin
			sel = s[1:0];
			tick(2);
			chk({1'b0, mhz}, 8'h50 >> s);
		end
		for (int k = 0; k < 8; k++) begin
			sel = 2'(k % 2);
			hi_v = (k < 2) ? t_hi[k] : 8'($urandom_range(255, 128));
			lo_v = (k < 2) ? t_lo[k] : 8'($urandom_range(127, 0));
			bt = (k < 2) ? t_bt[k] : 8'($urandom);
			frm(ADDR_UPPER, 1'b1, hi_v, r);
			frm(ADDR_LOWER, 1'b1, lo_v, r);
			frm(ADDR_UPPER, 1'b0, 8'h00, r);
			chk(r, hi_v);
			frm(ADDR_LOWER, 1'b0, 8'h00, r);
			chk(r, lo_v);
			chk(cl, clamp(bt, lo_v, hi_v));
		end
		host.xfer({8'h11, 1'b1, ADDR_UPPER}, 8, r);
		chk(up, hi_v);
		frm(7'h20, 1'b1, 8'hff, r);
		frm(7'h20, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		for (int k = 0; k < 7; k++) begin
			v = (k < 6) ? 6'(1 << k) : 6'($urandom);
			pulse(v, 7'h00);
			frm(ADDR_STAT_B, 1'b0, 8'hff, r);
			chk(r, bexp(v));
			frm(ADDR_STAT_B, 1'b0, 8'h00, r);
			chk(r, bexp(v));
			frm(ADDR_STAT_B, 1'b1, 8'hff, r);
			chk(r, bexp(v));
			frm(ADDR_STAT_B, 1'b0, 8'h00, r);
			chk(r, 8'h00);
		end
		// The event meets the clear edge alone, so only set-wins keeps it.
		fork
			frm(ADDR_STAT_B, 1'b1, 8'h00, r);
			begin
				@(posedge cs_n);
				chk({7'h00, oe}, 8'h01);
				bat = 1'b1;
				tick(1);
				bat = 1'b0;
			end
		join
		chk(r, 8'h00);
		chk({7'h00, oe}, 8'h00);
		frm(ADDR_STAT_B, 1'b0, 8'h00, r);
		chk(r, 8'h40);
		frm(ADDR_STAT_A, 1'b1, 8'h00, r);
		chk(r, 8'h80);
		v = 6'($urandom);
		va = 7'($urandom) | 7'h01;
		pulse(v, va);
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, {1'b0, va});
		frm(ADDR_STAT_A, 1'b1, 8'h00, r);
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		frm(ADDR_UPPER, 1'b1, 8'h12, r);
		chk(up, 8'h12);
		pulse(6'h3f, 7'h7f);
		soft_reset = 1'b1;
		tick(1);
		soft_reset = 1'b0;
		tick(1);
		chk(up, 8'ha8);
		frm(ADDR_STAT_B, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		nrst = 1'b0;
		tick(2);
		nrst = 1'b1;
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, 8'h80);
		soft_reset = 1'b1;
		tick(1);
		soft_reset = 1'b0;
		frm(ADDR_STAT_A, 1'b0, 8'h00, r);
		chk(r, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
